// ### logic/hfp_map.svh
// offsets-free constants for the host frame protocol controller
`ifndef HFP_MAP_SVH
`define HFP_MAP_SVH
`define HFP_START0 8'h00
`define HFP_START1 8'hff
`define HFP_ID_TO_DEV 8'hd4
`define HFP_ID_FROM_DEV 8'hd5
`define HFP_EXT_MARK 8'hff
`define HFP_PREAMBLE 8'h00
`define HFP_ACK_LEN 8'h00
`define HFP_ACK_LCS 8'hff
`define HFP_NACK_LEN 8'hff
`define HFP_NACK_LCS 8'h00
`define HFP_ERR_CMD 8'h7f
`define HFP_NORMAL_MAX 9'd255
`define HFP_EXT_MAX 9'd265
`define HFP_CLK_NS 100
`define HFP_RESP_TIMEOUT_MS 15
`define HFP_RESP_TIMEOUT_CYC ((`HFP_RESP_TIMEOUT_MS * 1000000) / `HFP_CLK_NS)
`endif

// ### logic/hfp_pkg.sv
// types for the host frame protocol controller
package hfp_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} hfp_byte_t;
	typedef enum logic [3:0] {
		TX_IDLE = 4'h0,
		TX_PRE = 4'h1,
		TX_S0 = 4'h2,
		TX_S1 = 4'h3,
		TX_LEN = 4'h4,
		TX_LCS = 4'h5,
		TX_EXH = 4'h6,
		TX_EXL = 4'h7,
		TX_EXC = 4'h8,
		TX_ID = 4'h9,
		TX_DATA = 4'ha,
		TX_DCS = 4'hb,
		TX_POST = 4'hc
	} hfp_tx_t;
	typedef enum logic [3:0] {
		RX_HUNT = 4'h0,
		RX_S1 = 4'h1,
		RX_LEN = 4'h2,
		RX_LCS = 4'h3,
		RX_EXH = 4'h4,
		RX_EXL = 4'h5,
		RX_EXC = 4'h6,
		RX_ID = 4'h7,
		RX_DATA = 4'h8,
		RX_DCS = 4'h9
	} hfp_rx_t;
endpackage

// ### logic/hfp_fifo.sv
// byte fifo between payload source and frame transmitter
`timescale 1ns/1ns
module hfp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic wr_ready;
	} hfp_fifo_st_t;
	logic [WIDTH-1:0] mem [DEPTH];
	hfp_fifo_st_t st;
	hfp_fifo_st_t next_st;
	logic full;
	logic empty;
	assign empty = st.wp == st.rp;
	assign full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
	assign wr_ready_out = st.wr_ready;
	assign rd_valid_out = !empty;
	assign rd_data_out = mem[st.rp[AW-1:0]];
	always_comb begin
		next_st = st;
		if (wr_valid_in && !full) begin
			next_st.wp = st.wp + 1'b1;
		end
		if (rd_ready_in && !empty) begin
			next_st.rp = st.rp + 1'b1;
		end
		// ready is registered from the pointers of the coming cycle
		next_st.wr_ready = !((next_st.wp[AW] != next_st.rp[AW])
			&& (next_st.wp[AW-1:0] == next_st.rp[AW-1:0]));
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '{wp: '0, rp: '0, wr_ready: 1'b1};
		end else begin
			st <= next_st;
		end
		if (wr_valid_in && !full) begin
			mem[st.wp[AW-1:0]] <= wr_data_in;
		end
	end
endmodule // hfp_fifo

// ### logic/hfp_host.sv
// host-side frame controller: builds command frames, parses device frames
`timescale 1ns/1ns
`include "hfp_map.svh"
// Operation
// - host sends only while not receiving a frame; half duplex
// - normal length byte counts identifier plus payload
// - length plus length checksum low byte is zero
// - identifier d4 host to device, d5 device to host
// - first payload byte is command; data checksum zeroes the sum
// - normal frame holds at most 255 bytes with identifier
// - extended frame: ff ff, high, low, checksum of both
// - host uses extended frame above 255; accepts either form
// - host may send acknowledge frame after good response
// - only host sends negative acknowledge; device then resends response
// - command, device acknowledge, response, optional host acknowledge
// - host sends one negative acknowledge per command, on bad or missing response
module hfp_host (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [8:0] cmd_len_in,
	input wire logic cmd_start_in,
	input wire logic [8:0] pay_data_in,
	input wire logic pay_valid_in,
	output logic pay_ready_out,
	input wire logic send_ack_in,
	input wire logic abort_in,
	output logic busy_out,
	output logic [7:0] tx_byte_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_valid_in,
	output logic [7:0] resp_data_out,
	output logic resp_valid_out,
	output logic resp_last_out,
	output logic ack_seen_out,
	output logic err_frame_out,
	output logic resp_bad_out,
	output logic timeout_out
);
	typedef struct packed {
		hfp_pkg::hfp_tx_t tx;
		hfp_pkg::hfp_rx_t rx;
		logic [8:0] tx_len;
		logic [8:0] tx_cnt;
		logic [7:0] tx_sum;
		logic tx_ext;
		logic [1:0] ctl;
		logic [8:0] rx_len;
		logic [8:0] rx_cnt;
		logic [7:0] rx_sum;
		logic [7:0] rx_lh;
		logic rx_err;
		logic waiting;
		logic nack_sent;
		logic [23:0] tmo;
		logic [7:0] tx_byte;
		logic tx_valid;
		logic [7:0] resp_data;
		logic resp_valid;
		logic resp_last;
		logic ack_seen;
		logic err_frame;
		logic resp_bad;
		logic timeout;
		logic busy;
	} hfp_st_t;
	localparam logic [1:0] CTL_NONE = 2'h0;
	localparam logic [1:0] CTL_ACK = 2'h1;
	localparam logic [1:0] CTL_NACK = 2'h2;
	localparam logic [23:0] TMO_CYC = 24'(`HFP_RESP_TIMEOUT_CYC);
	hfp_st_t st;
	hfp_st_t next_st;
	hfp_pkg::hfp_byte_t fifo_out;
	logic fifo_valid;
	logic fifo_pop;
	logic fifo_wready;
	logic tx_take;
	logic rx_idle;
	hfp_fifo #(.WIDTH(9), .DEPTH(8)) i_hfp_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_data_in(pay_data_in),
		.wr_valid_in(pay_valid_in),
		.wr_ready_out(fifo_wready),
		.rd_data_out(fifo_out),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(fifo_pop)
	);
	assign pay_ready_out = fifo_wready;
	assign tx_take = !st.tx_valid || tx_ready_in;
	assign fifo_pop = tx_take && st.tx == hfp_pkg::TX_DATA && fifo_valid && st.tx_cnt < st.tx_len;
	// a lone 00 postamble leaves the receiver waiting for ff: still between frames
	assign rx_idle = st.rx == hfp_pkg::RX_HUNT || st.rx == hfp_pkg::RX_S1;
	always_comb begin
		next_st = st;
		next_st.resp_valid = 1'b0;
		next_st.resp_last = 1'b0;
		next_st.ack_seen = 1'b0;
		next_st.err_frame = 1'b0;
		next_st.resp_bad = 1'b0;
		next_st.timeout = 1'b0;
		if (st.tx_valid && tx_ready_in) begin
			next_st.tx_valid = 1'b0;
		end
		// ---------------------------------------------------------------
		// transmitter
		// ---------------------------------------------------------------
		if (tx_take) begin
			unique case (st.tx)
				hfp_pkg::TX_IDLE: begin
					if (rx_idle && st.ctl != CTL_NONE) begin
						next_st.tx = hfp_pkg::TX_PRE;
						next_st.tx_len = '0;
					end else if (rx_idle && cmd_start_in) begin
						next_st.tx = hfp_pkg::TX_PRE;
						next_st.tx_len = cmd_len_in;
						next_st.tx_ext = cmd_len_in > `HFP_NORMAL_MAX;
						next_st.waiting = 1'b1;
						next_st.nack_sent = 1'b0;
					end else if (send_ack_in || abort_in) begin
						next_st.ctl = CTL_ACK;
						next_st.waiting = 1'b0;
					end
				end
				hfp_pkg::TX_PRE: begin
					next_st.tx_byte = `HFP_PREAMBLE;
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_S0;
				end
				hfp_pkg::TX_S0: begin
					next_st.tx_byte = `HFP_START0;
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_S1;
				end
				hfp_pkg::TX_S1: begin
					next_st.tx_byte = `HFP_START1;
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_LEN;
				end
				hfp_pkg::TX_LEN: begin
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_LCS;
					if (st.ctl == CTL_ACK) begin
						next_st.tx_byte = `HFP_ACK_LEN;
					end else if (st.ctl == CTL_NACK) begin
						next_st.tx_byte = `HFP_NACK_LEN;
					end else if (st.tx_ext) begin
						next_st.tx_byte = `HFP_EXT_MARK;
					end else begin
						next_st.tx_byte = st.tx_len[7:0];
					end
				end
				hfp_pkg::TX_LCS: begin
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_ID;
					if (st.ctl == CTL_ACK) begin
						next_st.tx_byte = `HFP_ACK_LCS;
						next_st.tx = hfp_pkg::TX_POST;
					end else if (st.ctl == CTL_NACK) begin
						next_st.tx_byte = `HFP_NACK_LCS;
						next_st.tx = hfp_pkg::TX_POST;
					end else if (st.tx_ext) begin
						next_st.tx_byte = `HFP_EXT_MARK;
						next_st.tx = hfp_pkg::TX_EXH;
					end else begin
						next_st.tx_byte = 8'(8'h00 - st.tx_len[7:0]);
					end
				end
				hfp_pkg::TX_EXH: begin
					next_st.tx_byte = {7'h00, st.tx_len[8]};
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_EXL;
				end
				hfp_pkg::TX_EXL: begin
					next_st.tx_byte = st.tx_len[7:0];
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_EXC;
				end
				hfp_pkg::TX_EXC: begin
					next_st.tx_byte = 8'(8'h00 - {7'h00, st.tx_len[8]} - st.tx_len[7:0]);
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_ID;
				end
				hfp_pkg::TX_ID: begin
					next_st.tx_byte = `HFP_ID_TO_DEV;
					next_st.tx_valid = 1'b1;
					next_st.tx_sum = `HFP_ID_TO_DEV;
					next_st.tx_cnt = 9'd1;
					next_st.tx = hfp_pkg::TX_DATA;
				end
				hfp_pkg::TX_DATA: begin
					if (st.tx_cnt >= st.tx_len) begin
						next_st.tx = hfp_pkg::TX_DCS;
					end else if (fifo_valid) begin
						next_st.tx_byte = fifo_out.data;
						next_st.tx_valid = 1'b1;
						next_st.tx_sum = 8'(st.tx_sum + fifo_out.data);
						next_st.tx_cnt = 9'(st.tx_cnt + 9'd1);
					end
				end
				hfp_pkg::TX_DCS: begin
					next_st.tx_byte = 8'(8'h00 - st.tx_sum);
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_POST;
				end
				hfp_pkg::TX_POST: begin
					next_st.tx_byte = `HFP_PREAMBLE;
					next_st.tx_valid = 1'b1;
					next_st.tx = hfp_pkg::TX_IDLE;
					next_st.ctl = CTL_NONE;
					next_st.tmo = '0;
				end
			endcase
		end
		// ---------------------------------------------------------------
		// response wait timer
		// ---------------------------------------------------------------
		if (st.waiting && st.tx == hfp_pkg::TX_IDLE && rx_idle) begin
			next_st.tmo = 24'(st.tmo + 24'h000001);
			if (st.tmo >= TMO_CYC) begin
				next_st.timeout = 1'b1;
				next_st.tmo = '0;
				if (st.nack_sent) begin
					next_st.waiting = 1'b0;
				end else begin
					next_st.ctl = CTL_NACK;
					next_st.nack_sent = 1'b1;
				end
			end
		end
		// ---------------------------------------------------------------
		// receiver
		// ---------------------------------------------------------------
		if (rx_valid_in) begin
			unique case (st.rx)
				hfp_pkg::RX_HUNT: begin
					if (rx_byte_in == `HFP_START0) begin
						next_st.rx = hfp_pkg::RX_S1;
					end
				end
				hfp_pkg::RX_S1: begin
					if (rx_byte_in == `HFP_START1) begin
						next_st.rx = hfp_pkg::RX_LEN;
					end else if (rx_byte_in != `HFP_START0) begin
						next_st.rx = hfp_pkg::RX_HUNT;
					end
				end
				hfp_pkg::RX_LEN: begin
					next_st.rx_lh = rx_byte_in;
					next_st.rx = hfp_pkg::RX_LCS;
				end
				hfp_pkg::RX_LCS: begin
					next_st.rx = hfp_pkg::RX_HUNT;
					if (st.rx_lh == `HFP_ACK_LEN && rx_byte_in == `HFP_ACK_LCS) begin
						next_st.ack_seen = 1'b1;
					end else if (st.rx_lh == `HFP_EXT_MARK && rx_byte_in == `HFP_EXT_MARK) begin
						next_st.rx = hfp_pkg::RX_EXH;
					end else if (8'(st.rx_lh + rx_byte_in) == 8'h00) begin
						next_st.rx_len = {1'b0, st.rx_lh};
						next_st.rx = hfp_pkg::RX_ID;
					end else begin
						next_st.resp_bad = 1'b1;
					end
				end
				hfp_pkg::RX_EXH: begin
					next_st.rx_lh = rx_byte_in;
					next_st.rx = hfp_pkg::RX_EXL;
				end
				hfp_pkg::RX_EXL: begin
					next_st.rx_len = {st.rx_lh[0], rx_byte_in};
					next_st.rx_sum = 8'(st.rx_lh + rx_byte_in);
					next_st.rx_err = st.rx_lh > 8'h01;
					next_st.rx = hfp_pkg::RX_EXC;
				end
				hfp_pkg::RX_EXC: begin
					next_st.rx = hfp_pkg::RX_ID;
					if (8'(st.rx_sum + rx_byte_in) != 8'h00 || st.rx_err) begin
						next_st.resp_bad = 1'b1;
						next_st.rx = hfp_pkg::RX_HUNT;
					end
				end
				hfp_pkg::RX_ID: begin
					next_st.rx_sum = rx_byte_in;
					next_st.rx_cnt = 9'd1;
					next_st.rx_err = rx_byte_in != `HFP_ID_FROM_DEV;
					next_st.rx = (st.rx_len > 9'd1) ? hfp_pkg::RX_DATA : hfp_pkg::RX_DCS;
				end
				hfp_pkg::RX_DATA: begin
					next_st.rx_sum = 8'(st.rx_sum + rx_byte_in);
					next_st.rx_cnt = 9'(st.rx_cnt + 9'd1);
					next_st.resp_data = rx_byte_in;
					next_st.resp_valid = 1'b1;
					if (st.rx_cnt == 9'd1 && rx_byte_in == `HFP_ERR_CMD) begin
						next_st.err_frame = 1'b1;
					end
					if (9'(st.rx_cnt + 9'd1) >= st.rx_len) begin
						next_st.rx = hfp_pkg::RX_DCS;
					end
				end
				hfp_pkg::RX_DCS: begin
					next_st.rx = hfp_pkg::RX_HUNT;
					next_st.resp_last = 1'b1;
					if (8'(st.rx_sum + rx_byte_in) != 8'h00 || st.rx_err) begin
						next_st.resp_bad = 1'b1;
						if (st.waiting && !st.nack_sent && st.ctl == CTL_NONE) begin
							next_st.ctl = CTL_NACK;
							next_st.nack_sent = 1'b1;
						end
					end else begin
						next_st.waiting = 1'b0;
						if (send_ack_in) begin
							next_st.ctl = CTL_ACK;
						end
					end
				end
				default: begin
					next_st.rx = hfp_pkg::RX_HUNT;
				end
			endcase
		end
		next_st.busy = next_st.tx != hfp_pkg::TX_IDLE || next_st.waiting;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign busy_out = st.busy;
	assign tx_byte_out = st.tx_byte;
	assign tx_valid_out = st.tx_valid;
	assign resp_data_out = st.resp_data;
	assign resp_valid_out = st.resp_valid;
	assign resp_last_out = st.resp_last;
	assign ack_seen_out = st.ack_seen;
	assign err_frame_out = st.err_frame;
	assign resp_bad_out = st.resp_bad;
	assign timeout_out = st.timeout;
	AST_ID_BYTE: assert property (@(posedge clk_in) disable iff (rst_in)
		st.tx == hfp_pkg::TX_ID && tx_take |=> tx_byte_out == 8'hd4 && tx_valid_out)
		else $error("identifier byte not d4");
	AST_HALF_DUPLEX: assert property (@(posedge clk_in) disable iff (rst_in)
		st.tx == hfp_pkg::TX_IDLE && !rx_idle |=> st.tx == hfp_pkg::TX_IDLE)
		else $error("transmit started during receive");
	AST_LCS: assert property (@(posedge clk_in) disable iff (rst_in)
		st.tx == hfp_pkg::TX_LCS && tx_take && st.ctl == CTL_NONE && !st.tx_ext
		|=> 8'(tx_byte_out + $past(st.tx_len[7:0])) == 8'h00)
		else $error("length checksum wrong");
	AST_HUNT: assert property (@(posedge clk_in) disable iff (rst_in)
		st.rx == hfp_pkg::RX_HUNT && rx_valid_in && rx_byte_in != 8'h00
		|=> st.rx == hfp_pkg::RX_HUNT)
		else $error("hunt left without start byte");
	AST_POST: assert property (@(posedge clk_in) disable iff (rst_in)
		st.rx == hfp_pkg::RX_DCS && rx_valid_in |=> st.rx == hfp_pkg::RX_HUNT && resp_last_out)
		else $error("no return to hunt after checksum");
	AST_BAD_LEN: assert property (@(posedge clk_in) disable iff (rst_in)
		st.rx == hfp_pkg::RX_LCS && rx_valid_in && 8'(st.rx_lh + rx_byte_in) != 8'h00
		&& st.rx_lh != 8'hff && !(st.rx_lh == 8'h00 && rx_byte_in == 8'hff)
		|=> resp_bad_out && !resp_valid_out)
		else $error("bad length checksum not dropped");
	AST_EXT: assert property (@(posedge clk_in) disable iff (rst_in)
		st.tx == hfp_pkg::TX_IDLE && tx_take && st.ctl == CTL_NONE && cmd_start_in
		&& rx_idle && cmd_len_in > 9'd255 |=> st.tx_ext)
		else $error("long command not extended");
	AST_NACK: assert property (@(posedge clk_in) disable iff (rst_in)
		st.ctl == CTL_NACK && st.tx == hfp_pkg::TX_LEN && tx_take |=> tx_byte_out == 8'hff)
		else $error("nack length byte wrong");
endmodule // hfp_host

// ### tb/hfp_dev_model.sv
// behavioural device at the far end of the host frame link
`timescale 1ns/1ns
module hfp_dev_model (
	input wire logic clk_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic [7:0] rx_byte_out,
	output logic rx_valid_out,
	input wire logic [1:0] mode_in,
	input wire logic slow_in
);
	// mode 0 echo, 1 error frame, 2 first reply corrupt, 3 silent
	// frame time limit after the length checksum: four 256-byte frames, 100 cycles a byte
	localparam longint TMO_NS = 4 * 256 * 100 * 100;
	int ok_cnt = 0;
	int ack_cnt = 0;
	int nack_cnt = 0;
	int last_len = 0;
	logic [7:0] last_cmd = 8'h00;
	logic [7:0] q[$];
	logic [7:0] last_resp[$];
	logic stall = 1'b0;
	always @(negedge clk_in) stall <= slow_in & ~stall;
	assign tx_ready_out = ~stall;
	always @(posedge clk_in) begin
		if (tx_valid_in === 1'b1 && tx_ready_out) q.push_back(tx_byte_in);
	end
	task automatic get(output logic [7:0] b);
		while (q.size() == 0) @(posedge clk_in);
		b = q.pop_front();
	endtask
	// released line shows the inverse of the last byte
	task automatic putq(input logic [7:0] f[$]);
		foreach (f[i]) begin
			@(negedge clk_in);
			rx_byte_out = f[i];
			rx_valid_out = 1'b1;
			@(negedge clk_in);
			rx_valid_out = 1'b0;
			rx_byte_out = ~f[i];
			if (slow_in) repeat (3) @(negedge clk_in);
		end
	endtask
	initial begin
		logic [7:0] b, pr, ln, lc, h, l, c, s;
		logic [7:0] d[$];
		logic [7:0] f[$];
		int n;
		time t0;
		rx_byte_out = 8'h00;
		rx_valid_out = 1'b0;
		forever begin
			pr = 8'h01;
			get(b);
			while (!(pr == 8'h00 && b == 8'hff)) begin
				pr = b;
				get(b);
			end
			get(ln);
			get(lc);
			t0 = $time;
			if (ln == 8'h00 && lc == 8'hff) begin
				ack_cnt++;
				continue;
			end
			if (ln == 8'hff && lc == 8'h00) begin
				nack_cnt++;
				putq(last_resp);
				continue;
			end
			n = ln;
			if (ln == 8'hff && lc == 8'hff) begin
				get(h);
				get(l);
				get(c);
				n = {h, l};
				if (8'(h + l + c) != 8'h00) continue;
			end else if (8'(ln + lc) != 8'h00) continue;
			get(b);
			s = b;
			d = {};
			for (int i = 1; i < n; i++) begin
				get(c);
				d.push_back(c);
				s += c;
			end
			get(c);
			if (b != 8'hd4 || 8'(s + c) != 8'h00 || n > 265) continue;
			if ($time - t0 > TMO_NS) continue;
			ok_cnt++;
			last_len = n;
			last_cmd = d[0];
			putq({8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00});
			if (mode_in == 2'd3) continue;
			if (mode_in == 2'd1) d = {8'h7f};
			else if (n > 8) d = {8'(d[0] + 8'h01)};
			else d[0] = d[0] + 8'h01;
			s = 8'hd5;
			foreach (d[i]) s += d[i];
			f = {8'h00, 8'h00, 8'hff, 8'(d.size() + 1), 8'(-(d.size() + 1)), 8'hd5};
			f = {f, d, 8'(-s), 8'h00};
			last_resp = f;
			if (mode_in == 2'd2) f[f.size() - 2] = f[f.size() - 2] + 8'h01;
			putq(f);
		end
	end
endmodule // hfp_dev_model

// ### tb/test_hfp_host.sv
// self-checking bench for the host frame controller
`timescale 1ns/1ns
module test_hfp_host;
	logic clk_in, rst_in, cmd_start_in, pay_valid_in, send_ack_in, abort_in, slow;
	logic pay_ready_out, busy_out, tx_valid_out, tx_ready, rx_valid, resp_valid_out;
	logic resp_last_out, ack_seen_out, err_frame_out, resp_bad_out, timeout_out;
	logic [8:0] cmd_len_in, pay_data_in;
	logic [7:0] tx_byte_out, rx_byte, resp_data_out;
	logic [1:0] mode;
	logic [7:0] txq[$];
	logic [7:0] rsq[$];
	int err_total = 0;
	int cmp_count = 0;
	int n_ack = 0, n_err = 0, n_bad = 0, n_last = 0;
	hfp_host i_hfp_host (.clk_in(clk_in), .rst_in(rst_in), .cmd_len_in(cmd_len_in),
		.cmd_start_in(cmd_start_in), .pay_data_in(pay_data_in), .pay_valid_in(pay_valid_in),
		.pay_ready_out(pay_ready_out), .send_ack_in(send_ack_in), .abort_in(abort_in),
		.busy_out(busy_out), .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
		.tx_ready_in(tx_ready), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
		.resp_data_out(resp_data_out), .resp_valid_out(resp_valid_out),
		.resp_last_out(resp_last_out), .ack_seen_out(ack_seen_out),
		.err_frame_out(err_frame_out), .resp_bad_out(resp_bad_out), .timeout_out(timeout_out));
	hfp_dev_model i_hfp_dev_model (.clk_in(clk_in), .tx_byte_in(tx_byte_out),
		.tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready), .rx_byte_out(rx_byte),
		.rx_valid_out(rx_valid), .mode_in(mode), .slow_in(slow));
	always @(posedge clk_in) begin
		if (tx_valid_out === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_byte_out);
		if (resp_valid_out === 1'b1) rsq.push_back(resp_data_out);
		n_ack += int'(ack_seen_out === 1'b1);
		n_err += int'(err_frame_out === 1'b1);
		n_bad += int'(resp_bad_out === 1'b1);
		n_last += int'(resp_last_out === 1'b1);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic put(input logic [7:0] b);
		int k = 0;
		pay_data_in = {b, 1'b0};
		pay_valid_in = 1'b1;
		while (pay_ready_out !== 1'b1 && k < 5000) begin
			@(negedge clk_in);
			k++;
		end
		@(negedge clk_in);
	endtask
	task automatic wait_idle();
		int k = 0, z = 0;
		while (z < 40 && k < 30000) begin
			@(negedge clk_in);
			k++;
			z = (busy_out === 1'b0) ? z + 1 : 0;
		end
		check("idle", k < 30000, 1);
	endtask
	task automatic run(input int n, input logic [7:0] c, input bit w);
		int i;
		put(c);
		for (i = 1; i < n - 1 && i < 8; i++) put(i[7:0]);
		if (n > 9) check("fifo full", pay_ready_out, 0);
		cmd_len_in = 9'(n);
		cmd_start_in = 1'b1;
		pay_valid_in = 1'b0;
		@(negedge clk_in);
		cmd_start_in = 1'b0;
		for (; i < n - 1; i++) put(i[7:0]);
		pay_valid_in = 1'b0;
		if (w) wait_idle();
	endtask
	task automatic t_plain();
		logic [7:0] e[$];
		int a0 = n_ack;
		txq = {};
		rsq = {};
		run(3, 8'h4a, 1);
		e = {8'h00, 8'h00, 8'hff, 8'h03, 8'hfd, 8'hd4, 8'h4a, 8'h01};
		e = {e, 8'(8'h00 - 8'hd4 - 8'h4a - 8'h01), 8'h00};
		check("tx count", txq.size(), 10);
		foreach (e[i]) check("tx byte", txq[i], e[i]);
		check("cmd", i_hfp_dev_model.last_cmd, 8'h4a);
		check("dev ack", n_ack - a0, 1);
		check("resp count", rsq.size(), 2);
		check("resp", {rsq[0], rsq[1]}, 16'h4b01);
		check("resp last", n_last, 1);
		@(negedge clk_in);
		send_ack_in = 1'b1;
		@(negedge clk_in);
		send_ack_in = 1'b0;
		wait_idle();
		check("host ack", i_hfp_dev_model.ack_cnt, 1);
		$display("test plain done");
	endtask
	task automatic t_ext();
		slow = 1'b1;
		txq = {};
		rsq = {};
		run(265, 8'h60, 1);
		check("ext mark", {txq[3], txq[4]}, 16'hffff);
		check("ext len", i_hfp_dev_model.last_len, 265);
		check("ext ok", i_hfp_dev_model.ok_cnt, 2);
		check("ext resp", rsq[0], 8'h61);
		slow = 1'b0;
		$display("test extended done");
	endtask
	task automatic t_err();
		int e0 = n_err;
		mode = 2'd1;
		run(2, 8'h10, 1);
		check("err frame", n_err - e0, 1);
		$display("test error frame done");
	endtask
	task automatic t_bad();
		int b0 = n_bad;
		mode = 2'd2;
		rsq = {};
		run(2, 8'h20, 1);
		check("bad seen", n_bad - b0, 1);
		check("nack sent", i_hfp_dev_model.nack_cnt, 1);
		check("resent", rsq[rsq.size() - 1], 8'h21);
		$display("test retransmit done");
	endtask
	task automatic t_abort();
		int k = 0;
		int a0 = n_ack;
		int h0 = i_hfp_dev_model.ack_cnt;
		mode = 2'd3;
		run(2, 8'h30, 0);
		while (n_ack == a0 && k < 5000) begin
			@(negedge clk_in);
			k++;
		end
		abort_in = 1'b1;
		@(negedge clk_in);
		abort_in = 1'b0;
		k = 0;
		while (i_hfp_dev_model.ack_cnt == h0 && k < 5000) begin
			@(negedge clk_in);
			k++;
		end
		check("abort ack", i_hfp_dev_model.ack_cnt - h0, 1);
		$display("test abort done");
	endtask
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		repeat (60000) @(posedge clk_in);
		err_total++;
		conclude();
	end
	initial begin
		rst_in = 1'b1;
		cmd_start_in = 1'b0;
		cmd_len_in = 9'h000;
		pay_data_in = 9'h000;
		pay_valid_in = 1'b0;
		send_ack_in = 1'b0;
		abort_in = 1'b0;
		slow = 1'b0;
		mode = 2'd0;
		repeat (8) @(negedge clk_in);
		rst_in = 1'b0;
		@(negedge clk_in);
		t_plain();
		t_ext();
		t_err();
		t_bad();
		t_abort();
		conclude();
	end
endmodule // test_hfp_host
